// >>> pkg/itc_consts.svh
// Register offsets, field positions, reset values and widths of the interval timer.
`ifndef ITC_CONSTS_SVH
`define ITC_CONSTS_SVH

// ==========================================================================
// Register byte offsets on the bus.
`define ITC_OFF_CTRL 8'h00
`define ITC_OFF_PRS 8'h04
`define ITC_OFF_CMP 8'h08
`define ITC_OFF_CNT 8'h0C
`define ITC_OFF_FLAG 8'h10
`define ITC_OFF_MASK 8'h14
`define ITC_ADDR_W 8

// ==========================================================================
// Field positions.
`define ITC_CTRL_RUN_BIT 7
`define ITC_CTRL_WIDTH_BIT 4
`define ITC_PRS_SEL_HI 7
`define ITC_PRS_SEL_LO 4
`define ITC_FLAG_BIT 0
`define ITC_MASK_BIT 0

// ==========================================================================
// Reset values.
`define ITC_CTRL_RST 8'h00
`define ITC_PRS_RST 8'h11
`define ITC_CMP_RST 16'h0000
`define ITC_CNT_RST 16'h0000
`define ITC_FLAG_RST 1'b0
`define ITC_MASK_RST 1'b1
`define ITC_RDATA_RST 32'h0000_0000

// ==========================================================================
// Widths and masks.
`define ITC_NARROW_MASK 16'h00FF
`define ITC_WIDE_MASK 16'hFFFF
`define ITC_ONE16 16'h0001
`define ITC_PRE_W 11
`define ITC_PRE_RST 11'h000
`define ITC_PRE_ONE 11'h001
`define ITC_DIV_MIN 12'h008
`define ITC_DIV_ONE 12'h001
`define ITC_DIV_MAX_CODE 4'h8
`define ITC_HTRANS_NONSEQ_BIT 1

`endif

// >>> pkg/itc_pkg.sv
// Types shared by the interval timer design files.
package itc_pkg;

  // ========================================================================
  // Counter sequencing states.
  typedef enum logic [1:0] {
    ST_STOP,
    ST_ARM,
    ST_RUN,
    ST_HALT
  } itc_state_type;

  typedef logic [3:0] itc_sel_type;
  typedef logic [15:0] itc_count_type;

endpackage : itc_pkg

// >>> design/itc_prescaler.sv
// Prescaler that turns the system clock into a one-cycle count enable.
`timescale 1ns/1ns
`include "itc_consts.svh"

module itc_prescaler
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Division select.
  input wire itc_pkg::itc_sel_type sel,
  // Count enable pulse.
  output logic tick
);
  import itc_pkg::*;

  // ========================================================================
  // Free-running divider and enable decode.
  logic [`ITC_PRE_W-1:0] pre_q;
  logic [`ITC_PRE_W-1:0] pre_d;
  logic [`ITC_PRE_W-1:0] div_mask;
  logic tick_q;
  logic tick_d;

  // The divisor is eight times two to the select; codes above eight stop the count.
  always_comb
  begin
    div_mask = `ITC_PRE_W'((`ITC_DIV_MIN << sel) - `ITC_DIV_ONE);
    pre_d = pre_q + `ITC_PRE_ONE;
    tick_d = (sel <= `ITC_DIV_MAX_CODE) && ((pre_q & div_mask) == div_mask);
  end

  // Registers of the divider.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre_q <= `ITC_PRE_RST;
      tick_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : itc_prescaler

// >>> design/itc_timer.sv
// Interval timer with compare match, 8 or 16 bit, behind an AHB-Lite slave.
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "itc_consts.svh"

module itc_timer
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave request.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // AHB-Lite slave response.
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Interrupt request.
  output logic match_irq
);
  import itc_pkg::*;

  // ========================================================================
  // Bus address phase capture.
  logic wr_pend_q;
  logic wr_pend_d;
  logic [`ITC_ADDR_W-1:0] addr_q;
  logic [`ITC_ADDR_W-1:0] addr_d;
  logic addr_take;
  logic wr_ctrl;
  logic wr_prs;
  logic wr_cmp;
  logic wr_flag;
  logic wr_mask;

  // A transfer is taken when selected, NONSEQ or SEQ, and the bus is ready.
  always_comb
  begin
    addr_take = hsel && htrans[`ITC_HTRANS_NONSEQ_BIT] && hready;
    wr_pend_d = addr_take && hwrite;
    addr_d = addr_take ? haddr[`ITC_ADDR_W-1:0] : addr_q;
    wr_ctrl = wr_pend_q && (addr_q == `ITC_OFF_CTRL);
    wr_prs = wr_pend_q && (addr_q == `ITC_OFF_PRS);
    wr_cmp = wr_pend_q && (addr_q == `ITC_OFF_CMP);
    wr_flag = wr_pend_q && (addr_q == `ITC_OFF_FLAG);
    wr_mask = wr_pend_q && (addr_q == `ITC_OFF_MASK);
  end

  // Registers of the address phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      addr_q <= `ITC_OFF_CTRL;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      addr_q <= addr_d;
    end
  end

  // ========================================================================
  // Software registers.
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] prs_q;
  logic [7:0] prs_d;
  itc_count_type cmp_q;
  itc_count_type cmp_d;
  logic mask_q;
  logic mask_d;
  logic run_now;
  logic run_next;
  logic wide;

  // Data-phase writes update the control, select, compare and mask registers.
  always_comb
  begin
    ctrl_d = wr_ctrl ? hwdata[7:0] : ctrl_q;
    prs_d = wr_prs ? hwdata[7:0] : prs_q;
    cmp_d = wr_cmp ? hwdata[15:0] : cmp_q;
    mask_d = wr_mask ? hwdata[`ITC_MASK_BIT] : mask_q;
    run_now = ctrl_q[`ITC_CTRL_RUN_BIT];
    run_next = ctrl_d[`ITC_CTRL_RUN_BIT];
    wide = ctrl_q[`ITC_CTRL_WIDTH_BIT];
  end

  // Registers written by software.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= `ITC_CTRL_RST;
      prs_q <= `ITC_PRS_RST;
      cmp_q <= `ITC_CMP_RST;
      mask_q <= `ITC_MASK_RST;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      prs_q <= prs_d;
      cmp_q <= cmp_d;
      mask_q <= mask_d;
    end
  end

  // ========================================================================
  // Count clock from the prescaler.
  logic tick;

  itc_prescaler u_itc_prescaler
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .sel(prs_q[`ITC_PRS_SEL_HI:`ITC_PRS_SEL_LO]),
    .tick(tick)
  );

  // ========================================================================
  // Counter sequencing.
  itc_state_type state_q;
  itc_state_type state_d;
  itc_count_type cnt_q;
  itc_count_type cnt_d;
  logic match_pend_q;
  logic match_pend_d;
  logic flag_q;
  logic flag_d;
  itc_count_type width_mask;
  itc_count_type cnt_inc;
  logic hit;
  logic run_rise;
  logic run_fall;
  logic flag_set;

  // Next count, state and match flag for each count clock and control write.
  always_comb
  begin
    width_mask = wide ? `ITC_WIDE_MASK : `ITC_NARROW_MASK;
    cnt_inc = (cnt_q + `ITC_ONE16) & width_mask;
    // A compare being written masks the comparison in this cycle.
    hit = (cnt_inc == (cmp_q & width_mask)) && !wr_cmp;
    run_rise = wr_ctrl && run_next && !run_now;
    run_fall = wr_ctrl && !run_next && run_now;
    state_d = state_q;
    cnt_d = cnt_q;
    match_pend_d = match_pend_q;
    flag_d = flag_q;
    flag_set = 1'b0;
    case (state_q)
      ST_STOP:
      begin
        if (run_rise)
        begin
          state_d = ST_ARM;
        end
      end
      ST_ARM:
      begin
        // The first count clock after the start only loads zero.
        if (tick)
        begin
          cnt_d = `ITC_CNT_RST;
          state_d = ST_RUN;
        end
        // A stop before counting begins still clears the count on the next count clock.
        if (run_fall)
        begin
          state_d = ST_HALT;
        end
      end
      ST_RUN:
      begin
        if (tick && match_pend_q)
        begin
          cnt_d = `ITC_CNT_RST;
          match_pend_d = 1'b0;
        end
        else if (tick)
        begin
          cnt_d = cnt_inc;
          if (hit)
          begin
            match_pend_d = 1'b1;
            flag_set = 1'b1;
          end
        end
        // A rewrite of one while running changes nothing.
        if (run_fall)
        begin
          state_d = ST_HALT;
          match_pend_d = 1'b0;
        end
      end
      ST_HALT:
      begin
        if (tick)
        begin
          cnt_d = `ITC_CNT_RST;
          state_d = run_rise ? ST_ARM : ST_STOP;
        end
        // Restart before the clearing count clock lets that clock start the count.
        if (run_rise && !tick)
        begin
          state_d = ST_ARM;
        end
      end
      default:
      begin
        state_d = ST_STOP;
      end
    endcase
    // A match wins over a software write of the flag in the same cycle.
    if (flag_set)
    begin
      flag_d = 1'b1;
    end
    else if (wr_flag)
    begin
      flag_d = hwdata[`ITC_FLAG_BIT];
    end
  end

  // Registers of the counter.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= ST_STOP;
      cnt_q <= `ITC_CNT_RST;
      match_pend_q <= 1'b0;
      flag_q <= `ITC_FLAG_RST;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      match_pend_q <= match_pend_d;
      flag_q <= flag_d;
    end
  end

  // ========================================================================
  // Bus response and interrupt output.
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irq_q;
  logic irq_d;

  // Read data follows the next values so a read after a write sees the write.
  always_comb
  begin
    rdata_d = rdata_q;
    if (addr_take && !hwrite)
    begin
      case (haddr[`ITC_ADDR_W-1:0])
        `ITC_OFF_CTRL: rdata_d = {24'h000000, ctrl_d};
        `ITC_OFF_PRS: rdata_d = {24'h000000, prs_d};
        `ITC_OFF_CMP: rdata_d = {16'h0000, cmp_d};
        `ITC_OFF_CNT: rdata_d = {16'h0000, cnt_d};
        `ITC_OFF_FLAG: rdata_d = {31'h00000000, flag_d};
        `ITC_OFF_MASK: rdata_d = {31'h00000000, mask_d};
        default: rdata_d = `ITC_RDATA_RST;
      endcase
    end
    irq_d = flag_d && !mask_d;
  end

  // Registers of the response.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdata_q <= `ITC_RDATA_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign hrdata = rdata_q;
  assign match_irq = irq_q;
  // The slave never inserts wait states and never reports an error.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule : itc_timer

// >>> tb/itc_timer_monitor.sv
// Checker for the bus answer and interrupt line of the interval timer.
`timescale 1ns/1ns

module itc_monitor
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Bus request.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // Bus answer and interrupt.
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic match_irq
);
  // Address phases that the slave takes.
  logic take;
  assign take = hsel & htrans[1] & hready;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ======================================================================
  // Bus answer and interrupt behaviour.
  ready_high_a: assert property (hreadyout) else $error("slave not ready");
  resp_okay_a: assert property (!hresp) else $error("error response");
  mask_irq_a: assert property (take && hwrite && haddr[7:0] == 8'h14 ##1 hwdata[0]
    |=> !match_irq) else $error("masked interrupt still high");
  unmapped_zero_a: assert property (take && !hwrite && haddr[7:0] == 8'h18
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  count_width_a: assert property (take && !hwrite && haddr[7:0] == 8'h0C
    |=> hrdata[31:16] == 16'h0) else $error("count wider than 16 bits");
  ctrl_width_a: assert property (take && !hwrite && haddr[7:0] == 8'h00
    |=> hrdata[31:8] == 24'h0) else $error("control wider than 8 bits");
  rdata_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  irq_reset_a: assert property ($rose(hresetn) |-> !match_irq)
    else $error("interrupt high after reset");
endmodule : itc_monitor

bind itc_timer itc_monitor u_itc_monitor (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .match_irq);

// >>> tb/itc_timer_tb.sv
// Self-checking testbench of the interval timer.
`timescale 1ns/1ns

module itc_timer_tb;
  import itc_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [15:0] v;} itc_row_type;
  typedef struct packed {logic [7:0] c; logic [3:0] s; logic [15:0] m; logic [11:0] k;}
    itc_mode_type;
  // Design ports and bench state.
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] d;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic match_irq;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int t;
  int n;
  int dv;
  int i;
  // Register accesses: write or read, offset, value.
  itc_row_type regs [18] = '{'{1'h0, 8'h00, 16'h0}, '{1'h0, 8'h04, 16'h11},
    '{1'h0, 8'h08, 16'h0}, '{1'h0, 8'h0C, 16'h0}, '{1'h0, 8'h10, 16'h0},
    '{1'h0, 8'h14, 16'h1}, '{1'h0, 8'h18, 16'h0}, '{1'h1, 8'h08, 16'h1234},
    '{1'h0, 8'h08, 16'h1234}, '{1'h1, 8'h00, 16'h10}, '{1'h0, 8'h00, 16'h10},
    '{1'h1, 8'h0C, 16'h5}, '{1'h0, 8'h0C, 16'h0}, '{1'h1, 8'h10, 16'h1},
    '{1'h0, 8'h10, 16'h1}, '{1'h1, 8'h10, 16'h0}, '{1'h1, 8'h18, 16'hFF},
    '{1'h0, 8'h18, 16'h0}};
  // Modes: control, select code, compare, count clocks per interval.
  itc_mode_type modes [11] = '{'{8'h80, 4'h0, 16'h2, 12'h3},
    '{8'h80, 4'h0, 16'h105, 12'h6}, '{8'h90, 4'h0, 16'h105, 12'h106},
    '{8'h80, 4'h1, 16'h1, 12'h2}, '{8'h80, 4'h2, 16'h1, 12'h2}, '{8'h80, 4'h3, 16'h1, 12'h2},
    '{8'h80, 4'h4, 16'h1, 12'h2}, '{8'h80, 4'h6, 16'h1, 12'h2}, '{8'h80, 4'h8, 16'h1, 12'h2},
    '{8'h80, 4'h7, 16'h1, 12'h2}, '{8'h80, 4'h5, 16'h3, 12'h4}};

  assign hready = hreadyout;

  itc_timer u_itc_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .match_irq(match_irq));

  // Clock of 50 ns and a cycle count for interval timing.
  initial forever #25 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  // ======================================================================
  // Reporting, compares and bus cycles.
  task end_sim();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  task err(input string s);
    $display("unexpected at %0t: %s", $time, s);
    n_fail++;
  endtask : err
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) err($sformatf("got %h want %h", g, e));
  endtask : chk
  task chkc(input int g, input int lo, input int hi);
    n_compared++;
    if (g < lo || g > hi) err($sformatf("interval %0d not in %0d..%0d", g, lo, hi));
  endtask : chkc
  // Waits for the edge at which ready is sampled high.
  task ph();
    int j;
    j = 0;
    @(posedge hclk);
    while (hreadyout !== 1'h1)
    begin
      j++;
      if (j > 50) begin err("bus hang"); end_sim(); end
      @(posedge hclk);
    end
  endtask : ph
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    ph();
    htrans <= 2'h0;
    hwdata <= v;
    ph();
    d = hrdata;
  endtask : xfer
  // Notes the cycle in which the interrupt line is first seen high.
  task wirq();
    int j;
    j = 0;
    @(negedge hclk);
    while (match_irq !== 1'h1)
    begin
      j++;
      if (j > 30000) begin err("no interrupt"); end_sim(); end
      @(negedge hclk);
    end
    t = cyc;
    @(posedge hclk);
  endtask : wirq

  // ======================================================================
  // Main sequence.
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    foreach (regs[r])
    begin
      xfer(regs[r].w, regs[r].a, {16'h0, regs[r].v});
      if (!regs[r].w) chk(d, {16'h0, regs[r].v});
    end
    // Each mode is started from a stop, timed once from the start and once exactly.
    foreach (modes[r])
    begin
      dv = 8 << modes[r].s;
      xfer(1'h1, 8'h00, 32'h0);
      xfer(1'h1, 8'h04, {24'h0, modes[r].s, 4'h0});
      xfer(1'h1, 8'h08, {16'h0, modes[r].m});
      xfer(1'h1, 8'h14, 32'h0);
      xfer(1'h1, 8'h10, 32'h0);
      n = cyc;
      xfer(1'h1, 8'h00, {24'h0, modes[r].c});
      wirq();
      chkc(t - n, (modes[r].k - 1) * dv, modes[r].k * dv + 4);
      n = t;
      xfer(1'h1, 8'h10, 32'h0);
      xfer(1'h1, 8'h00, {24'h0, modes[r].c});
      wirq();
      chkc(t - n, modes[r].k * dv, modes[r].k * dv);
    end
    xfer(1'h0, 8'h0C, 32'h0);
    chk(d, 32'h3);
    xfer(1'h1, 8'h10, 32'h0);
    i = 0;
    do begin xfer(1'h0, 8'h0C, 32'h0); i++; end while (d !== 32'h2 && i < 500);
    if (d !== 32'h2) begin err("count never reached two"); end_sim(); end
    xfer(1'h1, 8'h08, 32'h2);
    repeat (100) @(posedge hclk);
    chk({31'h0, match_irq}, 32'h0);
    xfer(1'h1, 8'h00, 32'h0);
    repeat (300) @(posedge hclk);
    xfer(1'h0, 8'h0C, 32'h0);
    chk(d, 32'h0);
    xfer(1'h1, 8'h10, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, match_irq}, 32'h1);
    xfer(1'h1, 8'h14, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, match_irq}, 32'h0);
    // A reset in mid-run must leave the count stopped at zero.
    xfer(1'h1, 8'h00, 32'h80);
    repeat (40) @(posedge hclk);
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    xfer(1'h0, 8'h0C, 32'h0);
    chk(d, 32'h0);
    xfer(1'h0, 8'h00, 32'h0);
    chk(d, 32'h0);
    end_sim();
  end
endmodule : itc_timer_tb
